// ==== verif/lms_checker.sv ====
// Checker for the line and modem status block, channel 0.
// Assumes it is bound to the block's top module and sees its ports only.
`timescale 1ns/10ps
module lms_checker #(parameter CHANNELS = 2, parameter AW = 8) (
   input wire logic                clock, rst_b, psel, penable, pwrite, pready, pslverr,
   input wire logic [AW-1:0]       paddr,
   input wire logic [31:0]         prdata,
   input wire logic [CHANNELS-1:0] rx_overrun, rx_data_full, exit_flag,
   input wire logic [CHANNELS-1:0] dma_halt, status_irq, rx_irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Halt follows the flag, which follows the pulse, one stage each
   a_halt_on_error: assert property (rx_overrun[0] |-> ##2 dma_halt[0])
      else $error("halt missing after overrun");
   a_exit_halts: assert property (exit_flag[0] |=> dma_halt[0])
      else $error("halt missing while exit flag set");
   a_irq_needs_flag: assert property (status_irq[0] |-> dma_halt[0])
      else $error("status interrupt without error flag");
   // Halt may only drop after a clearing write or the exit flag going away
   a_halt_holds: assert property ($fell(dma_halt[0]) |->
      $past(pwrite & penable, 2) || $past(exit_flag[0], 2))
      else $error("halt dropped without a clear");
   a_rx_irq_cause: assert property (rx_irq[0] |->
      $past(rx_data_full[0]) || $past(rx_data_full[0], 2))
      else $error("receive interrupt without data");
   a_ready_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not a single pulse after setup");
   a_unmapped_err: assert property (psel && !penable && paddr >= 'h20 |=> pslverr)
      else $error("no error on unmapped address");
   a_reserved_zero: assert property (pready && !pwrite && paddr[3:0] == 4'h0
      |-> prdata[31:6] == 26'h0)
      else $error("reserved line status bits not zero");
   c_halt: cover property (rx_overrun[0] ##2 dma_halt[0]);
   c_error: cover property (pslverr);
   c_clear: cover property ($fell(dma_halt[0]));
endmodule // lms_checker

bind uart_line_modem_status lms_checker #(.CHANNELS(CHANNELS), .AW(AW)) chk_u (
   .clock, .rst_b, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .prdata,
   .rx_overrun, .rx_data_full, .exit_flag, .dma_halt, .status_irq, .rx_irq);

// ==== verif/modem_model.sv ====
// Model of the modem equipment facing the serial pins.
// Assumes the bench sets channel 0 line levels right after a clock edge.
`timescale 1ns/10ps
module modem_model (
   input  wire logic       clock,
   output logic      [1:0] cts_n, dsr_n, ri_n, cd_n, serial_in
);
   logic [3:0] lvl_r = 4'hf; // Lines idle high, as pulled up at rest
   // Channel 1 and the data line stay idle, so they never raise change flags
   assign {cd_n[0], ri_n[0], dsr_n[0], cts_n[0]} = lvl_r;
   assign {cd_n[1], ri_n[1], dsr_n[1], cts_n[1]} = 4'hf;
   assign serial_in = 2'h3;
   task set_lines(input logic [3:0] v);
      lvl_r <= v;
   endtask
endmodule // modem_model

// ==== verif/tb_top.sv ====
// Self-checking bench for the line and modem status block.
// Assumes APB slave answers per its note; modem pins come from modem_model.
`timescale 1ns/10ps
module tb_top;
   logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [3:0]  err = 4'h0;
   logic [1:0]  rx_data_full = 2'h0, tx_data_empty = 2'h3, exit_flag = 2'h0;
   logic [1:0]  tx_serial = 2'h3, serial_in, cts_n, dsr_n, ri_n, cd_n, serial_out;
   logic [1:0]  dma_halt, status_irq, rx_irq, tx_irq;
   int fail_count = 0, total_checks = 0;
   uart_line_modem_status dut_u (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .rx_overrun({1'b0, err[0]}),
      .rx_parity_err({1'b0, err[1]}), .rx_framing_err({1'b0, err[2]}),
      .rx_break({1'b0, err[3]}), .rx_data_full, .tx_data_empty, .exit_flag,
      .tx_serial, .serial_in, .cts_n, .dsr_n, .ri_n, .cd_n, .serial_out,
      .rx_serial(), .dtr_n(), .rts_n(), .dma_halt, .status_irq, .rx_irq, .tx_irq,
      .modem_irq());
   modem_model modem_u (.clock, .cts_n, .dsr_n, .ri_n, .cd_n, .serial_in);
   initial forever #4 clock = ~clock;
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; the request holds until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1;
      @(posedge clock);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clock);
      end
      if (n == 50) fail_count++;
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task t_reset;
      apb(0, 8'h00, 32'h0);
      chk("line_status", rd, 32'h0000_0020);
      apb(0, 8'h04, 32'h0);
      chk("modem_status", rd, 32'h0);
      apb(1, 8'h20, 32'h00ff);
      chk("unmapped_err", er, 32'h1);
      $display("test reset done");
   endtask
   // Each error kind sets its bit and halts; write 0 keeps, write 1 clears
   task t_errors;
      for (int k = 0; k < 4; k++) begin
         err[k] <= 1;
         @(posedge clock);
         err[k] <= 0;
         repeat (2) @(posedge clock);
         chk("halt_set", dma_halt[0], 32'h1);
         apb(1, 8'h00, 32'h0);
         apb(0, 8'h00, 32'h0);
         chk("error_flag", rd, 32'h0020 | (32'h1 << k));
         apb(1, 8'h00, 32'h00ff);
         apb(0, 8'h00, 32'h0);
         chk("flag_cleared", rd, 32'h0020);
         chk("halt_clear", dma_halt[0], 32'h0);
      end
      exit_flag[0] <= 1;
      repeat (2) @(posedge clock);
      chk("exit_halt", dma_halt[0], 32'h1);
      exit_flag[0] <= 0;
      $display("test errors done");
   endtask
   task t_irq;
      err[1] <= 1;
      @(posedge clock);
      err[1] <= 0;
      repeat (2) @(posedge clock);
      chk("status_irq_off", status_irq[0], 32'h0);
      apb(1, 8'h0c, 32'h0002);
      repeat (2) @(posedge clock);
      chk("status_irq_on", status_irq[0], 32'h1);
      apb(1, 8'h00, 32'h0002);
      rx_data_full[0] <= 1;
      apb(1, 8'h0c, 32'h0004);
      repeat (2) @(posedge clock);
      chk("rx_tx_irq", {rx_irq[0], tx_irq[0], status_irq[0]}, 32'h6);
      apb(0, 8'h00, 32'h0);
      chk("full_empty", rd, 32'h0030);
      rx_data_full[0] <= 0;
      tx_data_empty[0] <= 0;
      repeat (3) @(posedge clock);
      chk("irq_idle", {rx_irq[0], tx_irq[0]}, 32'h0);
      tx_data_empty[0] <= 1;
      $display("test irq done");
   endtask
   // Lines low: three changes (ring leading edge does not count), then high
   task t_modem;
      modem_u.set_lines(4'h0);
      repeat (6) @(posedge clock);
      apb(0, 8'h04, 32'h0);
      chk("modem_low", rd, 32'h00fb);
      apb(1, 8'h04, 32'h000f);
      modem_u.set_lines(4'hf);
      repeat (6) @(posedge clock);
      apb(0, 8'h04, 32'h0);
      chk("modem_high", rd, 32'h000f);
      apb(1, 8'h04, 32'h000f);
      $display("test modem done");
   endtask
   task t_loop;
      int src[4] = '{5, 4, 6, 7};
      for (int i = 0; i < 4; i++) begin
         apb(1, 8'h08, 32'h0004 | (32'h1 << src[i]));
         apb(0, 8'h04, 32'h0);
         chk("loop_level", rd & 32'h00f0, 32'h0010 << i);
         chk("serial_out", serial_out[0], 32'h1);
      end
      apb(1, 8'h08, 32'h0);
      $display("test loopback done");
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1;
      t_reset;
      t_errors;
      t_irq;
      t_modem;
      t_loop;
      report_and_stop;
   end
   // Whole run needs about 150 cycles; this span is far beyond it
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
endmodule // tb_top

// ==== verilog/uart_line_modem_status.v ====
// Line status and modem status logic for a set of UART channels,
// with the modem control and interrupt mask registers they depend on.
// Assumes receiver events arrive as one-cycle pulses on this clock and
// modem pins arrive asynchronously from outside.
`timescale 1ns/10ps
`include "uart_line_modem_status_regs.vh"

module uart_line_modem_status #(
   parameter CHANNELS = 2,
   parameter AW       = 8
) (
   input  wire                clock,
   input  wire                rst_b,
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [AW-1:0]       paddr,
   input  wire [31:0]         pwdata,
   output reg  [31:0]         prdata,
   output reg                 pready,
   output reg                 pslverr,
   input  wire [CHANNELS-1:0] rx_overrun,
   input  wire [CHANNELS-1:0] rx_parity_err,
   input  wire [CHANNELS-1:0] rx_framing_err,
   input  wire [CHANNELS-1:0] rx_break,
   input  wire [CHANNELS-1:0] rx_data_full,
   input  wire [CHANNELS-1:0] tx_data_empty,
   input  wire [CHANNELS-1:0] exit_flag,
   input  wire [CHANNELS-1:0] tx_serial,
   input  wire [CHANNELS-1:0] serial_in,
   input  wire [CHANNELS-1:0] cts_n,
   input  wire [CHANNELS-1:0] dsr_n,
   input  wire [CHANNELS-1:0] ri_n,
   input  wire [CHANNELS-1:0] cd_n,
   output reg  [CHANNELS-1:0] serial_out,
   output reg  [CHANNELS-1:0] rx_serial,
   output reg  [CHANNELS-1:0] dtr_n,
   output reg  [CHANNELS-1:0] rts_n,
   output reg  [CHANNELS-1:0] dma_halt,
   output reg  [CHANNELS-1:0] status_irq,
   output reg  [CHANNELS-1:0] rx_irq,
   output reg  [CHANNELS-1:0] tx_irq,
   output reg  [CHANNELS-1:0] modem_irq
);

   localparam [2:0] NCH = CHANNELS;

   wire [1:0]            ch_idx;
   wire [1:0]            reg_idx;
   wire                  addr_bad;
   wire                  wr_en;
   wire [CHANNELS*8-1:0] ch_rd;
   wire [7:0]            rd_byte;
   wire [CHANNELS-1:0]   halt_w;
   wire [CHANNELS-1:0]   sirq_w;
   wire [CHANNELS-1:0]   rirq_w;
   wire [CHANNELS-1:0]   tirq_w;
   wire [CHANNELS-1:0]   mirq_w;
   wire [CHANNELS-1:0]   sout_w;
   wire [CHANNELS-1:0]   rxs_w;
   wire [CHANNELS-1:0]   dtr_w;
   wire [CHANNELS-1:0]   rts_w;

   // Address decode; anything outside the channel windows is an error
   assign ch_idx   = paddr[`CH_LSB+1:`CH_LSB];
   assign reg_idx  = paddr[3:2];
   assign addr_bad = (paddr[1:0] != 2'h0) || (paddr[AW-1:6] != 0) ||
                     ({1'b0, ch_idx} >= NCH);
   assign rd_byte  = addr_bad ? 8'h00 : ch_rd[ch_idx*8 +: 8];

   // Writes land only at the access edge that completes the transfer
   assign wr_en = psel && penable && pready && pwrite && !pslverr;

   // APB slave: one wait-free access phase, data captured at setup.
   // Capturing at setup keeps prdata a flip-flop output.
   always @(posedge clock) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && !penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= addr_bad;
         prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   genvar i;
   generate
      for (i = 0; i < CHANNELS; i = i + 1) begin : chan
         localparam [1:0] IDX = i;

         reg  [4:0] pin_s1_r;
         reg  [4:0] pin_s2_r;
         reg  [3:0] level_r;
         reg  [3:0] delta_r;
         reg  [3:0] err_r;
         reg        rxf_r;
         reg        txe_r;
         reg        srst_r;
         reg  [7:0] mcr_r;
         reg  [2:0] mask_r;
         reg  [7:0] rd_r;

         wire       hit;
         wire       loop;
         wire [3:0] loop_lvl;
         wire [3:0] level;
         wire [3:0] delta_ev;
         wire [3:0] err_ev;
         wire [3:0] err_clr;
         wire [3:0] delta_clr;

         assign hit  = wr_en && (ch_idx == IDX);
         assign loop = mcr_r[`MC_LOOPBACK];

         // Order is {carrier, ring, set ready, clear to send}
         assign loop_lvl = {mcr_r[7], mcr_r[6], mcr_r[4], mcr_r[5]};
         // Pins are active low, so level bits are inverted pins
         assign level = loop ? loop_lvl : ~pin_s2_r[3:0];

         // Changes against the previous level; ring only on release
         assign delta_ev = {level[3] ^ level_r[3],
                            level_r[2] & ~level[2],
                            level[1] ^ level_r[1],
                            level[0] ^ level_r[0]};

         assign err_ev = {rx_break[i], rx_framing_err[i],
                          rx_parity_err[i], rx_overrun[i]};

         // Write-one-to-clear strobes; a zero bit leaves the flag alone
         assign err_clr   = (hit && reg_idx == `REG_LINE_STATUS) ?
                            pwdata[3:0] : 4'h0;
         assign delta_clr = (hit && reg_idx == `REG_MODEM_STATUS) ?
                            pwdata[3:0] : 4'h0;

         // Modem pins cross into the clock domain through two flops
         always @(posedge clock) begin
            if (!rst_b) begin
               pin_s1_r <= `PIN_IDLE;
               pin_s2_r <= `PIN_IDLE;
            end else begin
               pin_s1_r <= {serial_in[i], cd_n[i], ri_n[i], dsr_n[i], cts_n[i]};
               pin_s2_r <= pin_s1_r;
            end
         end

         // Control and mask registers survive a soft reset
         always @(posedge clock) begin
            if (!rst_b) begin
               mcr_r  <= `MC_RESET;
               mask_r <= `MASK_RESET;
            end else begin
               if (hit && reg_idx == `REG_MODEM_CONTROL) begin
                  mcr_r <= pwdata[7:0] & `MC_WMASK;
               end
               if (hit && reg_idx == `REG_IRQ_MASK) begin
                  mask_r <= pwdata[2:0];
               end
            end
         end

         // Soft reset pulse: bit reads one for the cycle it acts
         always @(posedge clock) begin
            if (!rst_b) begin
               srst_r <= 1'b0;
            end else begin
               srst_r <= hit && (reg_idx == `REG_MODEM_CONTROL) &&
                         pwdata[`MC_SOFT_RESET];
            end
         end

         // Sticky flags: a new event in the clearing cycle wins
         always @(posedge clock) begin
            if (!rst_b || srst_r) begin
               err_r   <= 4'h0;
               delta_r <= 4'h0;
               level_r <= 4'h0;
               rxf_r   <= 1'b0;
               txe_r   <= `TXE_RESET;
            end else begin
               err_r   <= (err_r & ~err_clr) | err_ev;
               delta_r <= (delta_r & ~delta_clr) | delta_ev;
               level_r <= level;
               rxf_r   <= rx_data_full[i];
               txe_r   <= tx_data_empty[i];
            end
         end

         // Read view; unused status bits are fixed at zero
         always @* begin
            case (reg_idx)
               `REG_LINE_STATUS:   rd_r = {2'b00, txe_r, rxf_r, err_r};
               `REG_MODEM_STATUS:  rd_r = {level_r, delta_r};
               `REG_MODEM_CONTROL: rd_r = {mcr_r[7:1], srst_r};
               default:            rd_r = {5'h00, mask_r};
            endcase
         end

         assign ch_rd[i*8 +: 8] = rd_r;

         // Halt holds while any error flag or exit stays set
         assign halt_w[i] = (|err_r) | exit_flag[i];
         assign sirq_w[i] = mask_r[`MASK_STATUS_IE] & (|err_r);
         assign rirq_w[i] = mask_r[`MASK_TX_RX_IE] & rxf_r;
         assign tirq_w[i] = mask_r[`MASK_TX_RX_IE] & txe_r;
         assign mirq_w[i] = mask_r[`MASK_MODEM_IE] & (|delta_r);

         // Loopback: line idles high and the transmitter feeds the receiver
         assign sout_w[i] = loop ? 1'b1 : tx_serial[i];
         assign rxs_w[i]  = loop ? tx_serial[i] : pin_s2_r[4];
         // Handshake pins go inactive in loopback since the bits are looped
         assign dtr_w[i]  = loop ? 1'b1 : ~mcr_r[`MC_DTR];
         assign rts_w[i]  = loop ? 1'b1 : ~mcr_r[`MC_RTS];
      end
   endgenerate

   // All pin and request outputs leave from flip-flops
   always @(posedge clock) begin
      if (!rst_b) begin
         serial_out <= {CHANNELS{1'b1}};
         rx_serial  <= {CHANNELS{1'b1}};
         dtr_n      <= {CHANNELS{1'b1}};
         rts_n      <= {CHANNELS{1'b1}};
         dma_halt   <= {CHANNELS{1'b0}};
         status_irq <= {CHANNELS{1'b0}};
         rx_irq     <= {CHANNELS{1'b0}};
         tx_irq     <= {CHANNELS{1'b0}};
         modem_irq  <= {CHANNELS{1'b0}};
      end else begin
         serial_out <= sout_w;
         rx_serial  <= rxs_w;
         dtr_n      <= dtr_w;
         rts_n      <= rts_w;
         dma_halt   <= halt_w;
         status_irq <= sirq_w;
         rx_irq     <= rirq_w;
         tx_irq     <= tirq_w;
         modem_irq  <= mirq_w;
      end
   end

endmodule // uart_line_modem_status

// ==== verilog/uart_line_modem_status_regs.vh ====
// Register offsets, field positions and reset values for the line and
// modem status block. Assumes APB with 32-bit data, one word per register.
// Contract
// - Any error or exit flag halts DMA
// - Bit 0 sets on receiver overrun
// - Bit 1 sets on parity error
// - Framing error flag sets on framing error
// - Bit 3 sets on received break
// - Sticky flags clear only by writing one; the code also clears them on a soft reset
// - Bit 4 reads one while receive register full
// - Bit 5 resets one, reads one when transmit empty
// - Modem bit 0 latches clear-to-send change
// - Modem bit 1 latches set-ready change
// - Modem bit 2 latches ring trailing edge
// - Modem bit 3 latches carrier change
// - Loopback: modem bit 4 shows control bit 5
// - Loopback: modem bit 5 shows control bit 4
// - Loopback: modem bit 6 shows control bit 6
// - Loopback: modem bit 7 shows control bit 7
// - Level bits read one when input low
// - Control bit 2 selects loopback wiring
// - Mask bit 1 gates status interrupt
// - Mask bit 2 gates transmit/receive interrupts
`ifndef UART_LINE_MODEM_STATUS_REGS_VH
`define UART_LINE_MODEM_STATUS_REGS_VH

// Word index inside a channel window (paddr[3:2])
`define REG_LINE_STATUS    2'h0
`define REG_MODEM_STATUS   2'h1
`define REG_MODEM_CONTROL  2'h2
`define REG_IRQ_MASK       2'h3
// Channel window stride is 16 bytes: channel number sits in paddr[5:4]
`define CH_LSB             4

// Field positions
`define MC_SOFT_RESET      0
`define MC_LOOPBACK        2
`define MC_DTR             4
`define MC_RTS             5
`define MASK_MODEM_IE      0
`define MASK_STATUS_IE     1
`define MASK_TX_RX_IE      2

// Reset values and writable masks
`define MC_RESET           8'h00
`define MC_WMASK           8'hf6
`define MASK_RESET         3'h0
`define TXE_RESET          1'b1
`define PIN_IDLE           5'h1f

`endif
